// ---- verilog/ipps_top.v ----
`timescale 1ns/100ps
`include "ipps_defines.vh"

module ipps_top #(
    parameter LARGE_PACKAGE = 1,
    parameter ADDR_WIDTH = 8
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Peripheral interrupt requests, flag and enable already combined.
    input wire enhanced_capture_req,
    input wire timer3_overflow_req,
    input wire low_voltage_detect_req,
    input wire bus_collision_req,
    input wire eeprom_write_req,
    input wire comparator_req,
    // CAN interrupt requests, flag and enable already combined.
    input wire receive_buffer0_req,
    input wire receive_buffer1_req,
    input wire transmit_buffer0_req,
    input wire transmit_buffer1_req,
    input wire transmit_buffer2_req,
    input wire bus_error_req,
    input wire bus_wakeup_req,
    input wire invalid_message_req,
    // Routed requests towards the vectoring logic.
    output reg [`IPPS_NUM_SRC-1:0] source_high_level,
    output reg [`IPPS_NUM_SRC-1:0] source_low_level,
    output reg high_level_request,
    output reg low_level_request,
    output reg priority_scheme_active
);

    // Implemented bits of the second register depend on the package.
    localparam [7:0] MASK_B = (LARGE_PACKAGE != 0) ? `IPPS_MASK_B_LARGE : `IPPS_MASK_B_SMALL;
    localparam [7:0] RST_B = `IPPS_RST_PRIO_B & MASK_B;

    // Register state.
    reg [7:0] prio_b_reg;
    reg [7:0] prio_b_next;
    reg [7:0] can_reg;
    reg [7:0] can_next;
    reg ctrl_en_reg;
    reg ctrl_en_next;

    // Read path next values.
    reg [31:0] prdata_next;
    reg pslverr_next;

    // Bus decode.
    wire [5:0] word_idx;
    wire setup_phase;
    wire write_access;
    wire lane0_write;
    wire idx_prio_b;
    wire idx_can;
    wire idx_ctrl;
    wire idx_high;
    wire idx_low;
    wire idx_mapped;

    // Source packing and routing.
    wire [`IPPS_NUM_SRC-1:0] src_req;
    wire [`IPPS_NUM_SRC-1:0] src_prio;
    wire [`IPPS_NUM_SRC-1:0] eff_high;
    wire [`IPPS_NUM_SRC-1:0] high_next;
    wire [`IPPS_NUM_SRC-1:0] low_next;

    // Named priority fields of the second register.
    wire comparator_priority;
    wire eeprom_write_priority;
    wire bus_collision_priority;
    wire low_voltage_detect_priority;
    wire timer3_overflow_priority;
    wire enhanced_capture_priority;

    // Named priority fields of the CAN register.
    wire invalid_message_priority;
    wire bus_wakeup_priority;
    wire bus_error_priority;
    wire transmit_buffer2_priority;
    wire transmit_buffer1_priority;
    wire transmit_buffer0_priority;
    wire receive_buffer1_priority;
    wire receive_buffer0_priority;
    wire priority_scheme_enable;

    // Register map. Each register is one aligned 32-bit word and data sits in the low byte, or in bits 13:0 for the two pending words.
    // Index 0 holds peripheral_priority_select_b, readable and writable.
    // Index 1 holds can_priority_select, readable and writable.
    // Index 2 holds the control word, with priority_scheme_enable in bit 0.
    // Index 3 shows the pending sources routed to the high level and is read only.
    // Index 4 shows the pending sources routed to the low level and is read only.
    // Any other index answers with pslverr and leaves every register alone.
    // Writes to the two read-only words are dropped without an error.
    // Only byte lane 0 carries write data; the other strobes are ignored.

    // Source index used by every 14-bit request and routing vector of this block.
    // Bit 0 is the enhanced capture unit.
    // Bit 1 is the timer 3 overflow.
    // Bit 2 is the low-voltage detector.
    // Bit 3 is the bus collision detector.
    // Bit 4 is the EEPROM write completion.
    // Bit 5 is the comparator.
    // Bit 6 is CAN receive buffer 0.
    // Bit 7 is CAN receive buffer 1.
    // Bit 8 is CAN transmit buffer 0.
    // Bit 9 is CAN transmit buffer 1.
    // Bit 10 is CAN transmit buffer 2.
    // Bit 11 is the CAN bus error.
    // Bit 12 is the CAN bus activity wake-up.
    // Bit 13 is the CAN invalid message.

    // Bus timing. Read data and the error answer are latched at the setup edge.
    // They stand through the access phase, so pready can be tied high.
    // A write commits at the access edge, and a read whose setup edge comes later sees it.
    // Software that reads back right after a write therefore needs no extra wait.

    // Routing timing. Every routed output is registered, so a change of a request,
    // of a priority bit or of the enable shows at the outputs one edge later.
    // With the scheme disabled there is only one level, and it is the high one.
    // The low outputs then stay at zero whatever the priority bits hold.

    // Package variants. On the small package the comparator and capture bits do not
    // exist: they are masked on write and on read, so they always read as zero.
    // A comparator source that is still requested there would land on the low level
    // once the scheme is enabled, because its priority bit reads as zero.

    // The slave never inserts wait states.
    assign pready = 1'b1;

    // Address decode on word index; low address bits are ignored.
    assign word_idx = paddr[7:2];
    assign setup_phase = psel & ~penable;
    assign write_access = psel & penable & pwrite;
    assign lane0_write = write_access & pstrb[0];
    assign idx_prio_b = (word_idx == `IPPS_IDX_PRIO_B);
    assign idx_can = (word_idx == `IPPS_IDX_CAN);
    assign idx_ctrl = (word_idx == `IPPS_IDX_CTRL);
    assign idx_high = (word_idx == `IPPS_IDX_HIGH_PEND);
    assign idx_low = (word_idx == `IPPS_IDX_LOW_PEND);
    assign idx_mapped = idx_prio_b | idx_can | idx_ctrl | idx_high | idx_low;

    // Field views of the second register.
    assign comparator_priority = prio_b_reg[`IPPS_B_CMP];
    assign eeprom_write_priority = prio_b_reg[`IPPS_B_EE];
    assign bus_collision_priority = prio_b_reg[`IPPS_B_BCL];
    assign low_voltage_detect_priority = prio_b_reg[`IPPS_B_LVD];
    assign timer3_overflow_priority = prio_b_reg[`IPPS_B_TMR3];
    assign enhanced_capture_priority = prio_b_reg[`IPPS_B_ECC];

    // Field views of the CAN register.
    assign invalid_message_priority = can_reg[`IPPS_C_IRX];
    assign bus_wakeup_priority = can_reg[`IPPS_C_WAK];
    assign bus_error_priority = can_reg[`IPPS_C_ERR];
    assign transmit_buffer2_priority = can_reg[`IPPS_C_TXB2];
    assign transmit_buffer1_priority = can_reg[`IPPS_C_TXB1];
    assign transmit_buffer0_priority = can_reg[`IPPS_C_TXB0];
    assign receive_buffer1_priority = can_reg[`IPPS_C_RXB1];
    assign receive_buffer0_priority = can_reg[`IPPS_C_RXB0];
    assign priority_scheme_enable = ctrl_en_reg;

    // Pack the requests; index order matches the priority vector below.
    assign src_req = {
        invalid_message_req,
        bus_wakeup_req,
        bus_error_req,
        transmit_buffer2_req,
        transmit_buffer1_req,
        transmit_buffer0_req,
        receive_buffer1_req,
        receive_buffer0_req,
        comparator_req,
        eeprom_write_req,
        bus_collision_req,
        low_voltage_detect_req,
        timer3_overflow_req,
        enhanced_capture_req
    };

    // Pack the priority bits in the same order as the requests.
    assign src_prio = {
        invalid_message_priority,
        bus_wakeup_priority,
        bus_error_priority,
        transmit_buffer2_priority,
        transmit_buffer1_priority,
        transmit_buffer0_priority,
        receive_buffer1_priority,
        receive_buffer0_priority,
        comparator_priority,
        eeprom_write_priority,
        bus_collision_priority,
        low_voltage_detect_priority,
        timer3_overflow_priority,
        enhanced_capture_priority
    };

    // Per-source routing: a set bit sends the source to the high level.
    // With the scheme disabled every source lands on the single high level.
    genvar gi;
    generate
        for (gi = 0; gi < `IPPS_NUM_SRC; gi = gi + 1) begin : g_route
            assign eff_high[gi] = priority_scheme_enable ? src_prio[gi] : 1'b1;
            assign high_next[gi] = src_req[gi] & eff_high[gi];
            assign low_next[gi] = src_req[gi] & ~eff_high[gi];
        end
    endgenerate

    // Next values of the writable registers; only byte lane 0 carries data.
    always @* begin
        prio_b_next = prio_b_reg;
        can_next = can_reg;
        ctrl_en_next = ctrl_en_reg;
        if (lane0_write && idx_prio_b) begin
            // Unimplemented bits are masked so they stay zero.
            prio_b_next = pwdata[7:0] & MASK_B;
        end
        if (lane0_write && idx_can) begin
            can_next = pwdata[7:0] & `IPPS_MASK_CAN;
        end
        if (lane0_write && idx_ctrl) begin
            ctrl_en_next = pwdata[`IPPS_CTRL_EN];
        end
    end

    // Register storage; implemented priority bits come up as high priority.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_b_reg <= RST_B;
            can_reg <= `IPPS_RST_CAN;
            ctrl_en_reg <= `IPPS_RST_CTRL;
        end else begin
            prio_b_reg <= prio_b_next;
            can_reg <= can_next;
            ctrl_en_reg <= ctrl_en_next;
        end
    end

    // Read mux, evaluated in the setup phase; upper bits read as zero.
    always @* begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (!idx_mapped) begin
            pslverr_next = 1'b1;
        end else if (idx_prio_b) begin
            prdata_next = {24'h00_0000, prio_b_reg & MASK_B};
        end else if (idx_can) begin
            prdata_next = {24'h00_0000, can_reg};
        end else if (idx_ctrl) begin
            prdata_next = {31'h0000_0000, ctrl_en_reg};
        end else if (idx_high) begin
            prdata_next = {18'h0_0000, source_high_level};
        end else begin
            prdata_next = {18'h0_0000, source_low_level};
        end
    end

    // Capture read data and the error answer at the setup edge.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // Registered routing outputs towards the vectoring logic.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_high_level <= 14'h0000;
            source_low_level <= 14'h0000;
            high_level_request <= 1'b0;
            low_level_request <= 1'b0;
            priority_scheme_active <= 1'b0;
        end else begin
            source_high_level <= high_next;
            source_low_level <= low_next;
            high_level_request <= |high_next;
            low_level_request <= |low_next;
            priority_scheme_active <= priority_scheme_enable;
        end
    end

endmodule

// ---- verilog/ipps_defines.vh ----
`ifndef IPPS_DEFINES_VH
`define IPPS_DEFINES_VH

// Word indices of the registers (byte address = index * 4).
`define IPPS_IDX_PRIO_B 6'h00
`define IPPS_IDX_CAN 6'h01
`define IPPS_IDX_CTRL 6'h02
`define IPPS_IDX_HIGH_PEND 6'h03
`define IPPS_IDX_LOW_PEND 6'h04

// Field positions in peripheral_priority_select_b.
`define IPPS_B_CMP 3'h6
`define IPPS_B_EE 3'h4
`define IPPS_B_BCL 3'h3
`define IPPS_B_LVD 3'h2
`define IPPS_B_TMR3 3'h1
`define IPPS_B_ECC 3'h0

// Field positions in can_priority_select.
`define IPPS_C_IRX 3'h7
`define IPPS_C_WAK 3'h6
`define IPPS_C_ERR 3'h5
`define IPPS_C_TXB2 3'h4
`define IPPS_C_TXB1 3'h3
`define IPPS_C_TXB0 3'h2
`define IPPS_C_RXB1 3'h1
`define IPPS_C_RXB0 3'h0

// Field position in the control register.
`define IPPS_CTRL_EN 3'h0

// Implemented-bit masks for the two package variants.
`define IPPS_MASK_B_LARGE 8'h5F
`define IPPS_MASK_B_SMALL 8'h1E
`define IPPS_MASK_CAN 8'hFF

// Reset values.
`define IPPS_RST_PRIO_B 8'h5F
`define IPPS_RST_CAN 8'hFF
`define IPPS_RST_CTRL 1'h0

// Number of routed sources.
`define IPPS_NUM_SRC 14

`endif

// ---- bench/ipps_monitor.sv ----
`timescale 1ns/100ps
module ipps_monitor #(
    parameter LARGE_PACKAGE = 1,
    parameter ADDR_WIDTH = 8
) (
    // Clock, reset and bus.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    // Routed outputs.
    input wire [13:0] source_high_level,
    input wire [13:0] source_low_level,
    input wire priority_scheme_active
);
    logic [7:0] b_sh, c_sh;
    logic en_sh;
    wire [13:0] prv = {c_sh, b_sh[6], b_sh[4:0]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow copies follow committed writes so routing can be judged.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_sh <= LARGE_PACKAGE ? 8'h5F : 8'h1E;
            c_sh <= 8'hFF;
            en_sh <= 1'b0;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            if (paddr[7:2] == 6'h00) b_sh <= pwdata[7:0] & (LARGE_PACKAGE ? 8'h5F : 8'h1E);
            if (paddr[7:2] == 6'h01) c_sh <= pwdata[7:0];
            if (paddr[7:2] == 6'h02) en_sh <= pwdata[0];
        end
    end
    sequence rd_acc(logic [5:0] ix);
        psel && penable && !pwrite && paddr[7:2] == ix;
    endsequence
    AST_HIGH_ROUTE: assert property (priority_scheme_active |->
        (source_high_level & ~$past(prv)) == 14'h0) else $error("High routing wrong.");
    AST_LOW_ROUTE: assert property (priority_scheme_active |->
        (source_low_level & $past(prv)) == 14'h0) else $error("Low routing wrong.");
    AST_ONE_LEVEL: assert property ((source_high_level & source_low_level) == 14'h0)
        else $error("Source on both levels.");
    AST_FLAT_LOW: assert property (!priority_scheme_active |-> source_low_level == 14'h0)
        else $error("Low level used while scheme off.");
    AST_EN_COPY: assert property (priority_scheme_active == $past(en_sh))
        else $error("Scheme flag does not follow control.");
    AST_RD_B: assert property (rd_acc(6'h00) |-> prdata[7:0] == b_sh)
        else $error("Peripheral register read wrong.");
    AST_RD_C: assert property (rd_acc(6'h01) |-> prdata[7:0] == c_sh)
        else $error("CAN register read wrong.");
    AST_RSVD: assert property (rd_acc(6'h00) |-> !prdata[7] && !prdata[5])
        else $error("Reserved bits read nonzero.");
    AST_SMALL: assert property (rd_acc(6'h00) |-> LARGE_PACKAGE != 0 ||
        (prdata[7:0] & 8'h41) == 8'h00) else $error("Absent bits read nonzero.");
endmodule
bind ipps_top ipps_monitor #(.LARGE_PACKAGE(LARGE_PACKAGE), .ADDR_WIDTH(ADDR_WIDTH)) i_ipps_monitor (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .source_high_level, .source_low_level, .priority_scheme_active);

// ---- bench/peripheral_irq_priority_select_test.sv ----
`timescale 1ns/100ps
module peripheral_irq_priority_select_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, act, hr, lr;
    logic [31:0] prdata_s, rd_s;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed, rd;
    logic [3:0] pstrb;
    logic [13:0] req, hi, lo;
    int err_count, checks, b, c, en, i;
    ipps_top i_ipps_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .enhanced_capture_req(req[0]), .timer3_overflow_req(req[1]),
        .low_voltage_detect_req(req[2]), .bus_collision_req(req[3]), .eeprom_write_req(req[4]),
        .comparator_req(req[5]), .receive_buffer0_req(req[6]), .receive_buffer1_req(req[7]),
        .transmit_buffer0_req(req[8]), .transmit_buffer1_req(req[9]),
        .transmit_buffer2_req(req[10]), .bus_error_req(req[11]), .bus_wakeup_req(req[12]),
        .invalid_message_req(req[13]), .source_high_level(hi), .source_low_level(lo),
        .high_level_request(hr), .low_level_request(lr), .priority_scheme_active(act));
    // Small package variant on the same bus; its read data is compared against the mask.
    ipps_top #(.LARGE_PACKAGE(0)) i_ipps_top_small (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready(), .prdata(prdata_s), .pslverr(),
        .enhanced_capture_req(req[0]), .timer3_overflow_req(req[1]),
        .low_voltage_detect_req(req[2]), .bus_collision_req(req[3]), .eeprom_write_req(req[4]),
        .comparator_req(req[5]), .receive_buffer0_req(req[6]), .receive_buffer1_req(req[7]),
        .transmit_buffer0_req(req[8]), .transmit_buffer1_req(req[9]),
        .transmit_buffer2_req(req[10]), .bus_error_req(req[11]), .bus_wakeup_req(req[12]),
        .invalid_message_req(req[13]), .source_high_level(), .source_low_level(),
        .high_level_request(), .low_level_request(), .priority_scheme_active());
    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task close_out();
        $display("Checks %0d, errors %0d.", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [39:0] s, input logic [39:0] x);
        checks++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] mdl(input logic [5:0] ix);
        return ix == 0 ? b : ix == 1 ? c : ix == 2 ? en : 0;
    endfunction
    // One APB transfer; the answer is taken at the edge where pready is seen.
    task apb(input logic w, input logic [5:0] ix, input logic [7:0] d, input logic s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'h0};
        pwdata <= {24'h0, d};
        pstrb <= {3'h0, s};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            close_out();
        end
        rd = prdata;
        rd_s = prdata_s;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rst_chk();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        b = 8'h5F;
        c = 8'hFF;
        en = 0;
        for (i = 0; i < 3; i++) begin
            apb(1'b0, i[5:0], 8'h0, 1'b0);
            chk("reset", {e, rd}, {1'b0, mdl(i[5:0])});
            chk("small reset", rd_s, i == 0 ? mdl(i[5:0]) & 32'h1E : mdl(i[5:0]));
        end
    endtask
    // Random access, readback, then routing of random requests.
    task step(input logic [31:0] r);
        logic [5:0] ix;
        logic [13:0] pv, eh, el;
        ix = (r[1:0] == 2'h3) ? 6'h07 : {4'h0, r[1:0]};
        apb(r[2], ix, r[15:8], r[3]);
        chk("access", {e, rd}, {ix > 6'h04, r[2] ? 32'h0 : mdl(ix)});
        if (r[2] && r[3]) begin
            if (ix == 0) b = r[15:8] & 8'h5F;
            if (ix == 1) c = r[15:8];
            if (ix == 2) en = r[8];
        end
        apb(1'b0, ix, 8'h0, 1'b0);
        chk("readback", {e, rd}, {ix > 6'h04, mdl(ix)});
        chk("small readback", rd_s, ix == 6'h00 ? mdl(ix) & 32'h1E : mdl(ix));
        req <= r[29:16];
        pv = {c[7:0], b[6], b[4:0]};
        eh = en ? r[29:16] & pv : r[29:16];
        el = en ? r[29:16] & ~pv : 14'h0;
        repeat (2) @(posedge pclk);
        chk("high", hi, eh);
        chk("low", lo, el);
        chk("high request", hr, |eh);
        chk("low request", lr, |el);
        chk("active", act, en);
        apb(1'b0, 6'h03, 8'h0, 1'b0);
        chk("high pending", {e, rd}, {1'b0, 18'h0, eh});
        apb(1'b0, 6'h04, 8'h0, 1'b0);
        chk("low pending", {e, rd}, {1'b0, 18'h0, el});
    endtask
    // Main sequence, with a second reset after the random steps.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, req} = 0;
        seed = 32'h8BC5;
        err_count = 0;
        checks = 0;
        rst_chk();
        $display("Reset test done.");
        repeat (80) step(rnd());
        $display("Random test done.");
        rst_chk();
        $display("Second reset test done.");
        close_out();
    end
endmodule
